// ===== bench/sqs_host_model.sv
`timescale 1ns/100ps
module sqs_host_model
(
   input  wire       req_valid,
   input  wire       frm_from_host,
   input  wire [2:0] stp_state,
   output wire       frm_valid
);
   assign frm_valid = req_valid &
                      ~(frm_from_host & (stp_state < 3'h2));
endmodule

// ===== bench/sqs_policy_assertions.sv
`timescale 1ns/100ps
module sqs_policy_chk
(
   input wire        core_clk,
   input wire        srst,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire        frm_valid,
   input wire        frm_to_host,
   input wire        frm_from_host,
   input wire        frm_ovr_hit,
   input wire        res_valid,
   input wire [1:0]  res_queue,
   input wire        res_forward,
   input wire        res_learn,
   input wire [1:0]  cfg_queue_mode,
   input wire [2:0]  stp_state,
   input wire        host_port
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);

   rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("stray read data");
   res_latency_a: assert property (frm_valid |-> ##2 res_valid)
      else $error("late result");
   res_source_a: assert property (res_valid |-> $past(frm_valid, 2))
      else $error("stray result");
   single_queue_a: assert property (
      res_valid && cfg_queue_mode == 2'h0 |-> res_queue == 2'h0)
      else $error("queue above 0");
   two_queue_a: assert property (
      res_valid && cfg_queue_mode == 2'h1 |-> !res_queue[1])
      else $error("queue above 1");
   host_state_a: assert property (
      host_port && $past(host_port) |-> stp_state == 3'h5)
      else $error("not host state");
   no_learn_a: assert property (
      res_valid && stp_state < 3'h3 |-> !res_learn)
      else $error("learned while off");
   fwd_learn_a: assert property (
      res_valid && stp_state == 3'h4 && !$past(frm_from_host, 2)
      |-> res_forward && res_learn)
      else $error("no forward or learn");
   disable_ovr_a: assert property (
      res_valid && stp_state == 3'h0 |-> res_forward ==
      ($past(frm_to_host, 2) && $past(frm_ovr_hit, 2)))
      else $error("bad forward");
endmodule

bind sqs_policy sqs_policy_chk chk_u
(
   .core_clk(core_clk), .srst(srst), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .frm_valid(frm_valid),
   .frm_to_host(frm_to_host), .frm_from_host(frm_from_host),
   .frm_ovr_hit(frm_ovr_hit), .res_valid(res_valid),
   .res_queue(res_queue), .res_forward(res_forward),
   .res_learn(res_learn), .cfg_queue_mode(cfg_queue_mode),
   .stp_state(stp_state), .host_port(host_port)
);

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`include "sqs_policy_regs.vh"
module tb_top;
   reg         core_clk, srst, reg_wr, reg_rd, rq;
   reg  [8:0]  reg_addr;
   reg  [31:0] reg_wdata;
   reg  [15:0] frm_len;
   reg  [2:0]  frm_pcp;
   reg  [5:0]  frm_dscp;
   reg  [1:0]  frm_color;
   reg         frm_tagged, frm_is_ip, frm_sr;
   reg         frm_to_host, frm_from_host, frm_ovr_hit;
   reg  [11:0] mem_occupancy, tc_depth;
   wire [31:0] reg_rdata;
   wire [2:0]  res_pcp, stp_state;
   wire [1:0]  res_queue, res_color, cfg_queue_mode;
   wire        frm_valid, res_valid, res_drop, res_forward, res_learn;
   wire        cfg_wrr, host_port;
   integer     n_fail, checks_done, cyc, m;

   sqs_host_model host_u (.req_valid(rq), .frm_from_host(frm_from_host),
      .stp_state(stp_state), .frm_valid(frm_valid));
   sqs_policy dut_u (.core_clk(core_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
      .frm_len(frm_len), .frm_tagged(frm_tagged), .frm_pcp(frm_pcp),
      .frm_is_ip(frm_is_ip), .frm_dscp(frm_dscp), .frm_color(frm_color),
      .frm_sr(frm_sr), .frm_to_host(frm_to_host),
      .frm_from_host(frm_from_host), .frm_ovr_hit(frm_ovr_hit),
      .mem_occupancy(mem_occupancy), .tc_depth(tc_depth),
      .res_valid(res_valid), .res_queue(res_queue), .res_pcp(res_pcp),
      .res_color(res_color), .res_drop(res_drop),
      .res_forward(res_forward), .res_learn(res_learn),
      .cfg_queue_mode(cfg_queue_mode), .cfg_wrr(cfg_wrr),
      .stp_state(stp_state), .host_port(host_port));

   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (s !== e)
         begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task wr(input [8:0] a, input [31:0] d);
      begin
         @(posedge core_clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge core_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rdc(input [8:0] a, input [31:0] e);
      begin
         @(posedge core_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         #1;
         chk("reg_rdata", reg_rdata, e);
      end
   endtask
   task send(input [15:0] l, input [2:0] p, input t, input ip,
             input [5:0] d, input [1:0] c, input s, input [2:0] h);
      begin
         @(posedge core_clk);
         rq <= 1'b1;
         {frm_len, frm_pcp, frm_tagged, frm_is_ip, frm_dscp, frm_color,
          frm_sr, frm_to_host, frm_from_host, frm_ovr_hit} <=
            {l, p, t, ip, d, c, s, h};
         @(posedge core_clk);
         rq <= 1'b0;
         @(posedge core_clk);
         #1;
         chk("res_valid", res_valid, 1'h1);
      end
   endtask
   task pc(input [31:0] d);
      wr(`SQS_OFS_PORT_CTRL, d);
   endtask
   task sd(input [15:0] l, input [1:0] c, input s, input [2:0] h);
      send(l, 3'h0, 1'h0, 1'h0, 6'h0, c, s, h);
   endtask
   task t_regs;
      begin
         rdc(`SQS_OFS_PORT_CTRL, 32'h00000300);
         rdc(`SQS_OFS_PCP_MAP, 32'h0000FA50);
         rdc(9'h008, 32'hFFFFFFFF);
         rdc(`SQS_OFS_WRED, 32'h40C00800);
         rdc(9'h018, 32'h00000000);
         pc(32'hFFFC0304);
         rdc(`SQS_OFS_PORT_CTRL, 32'h00000304);
         chk("cfg_wrr", cfg_wrr, 1'h1);
      end
   endtask
   task t_queue;
      begin
         for (m = 0; m < 3; m = m + 1)
         begin
            pc(32'h00000308 | m);
            sd(16'h0040, 2'h0, 1'h0, 3'h0);
            chk("queue", res_queue, (m == 2) ? 3 : m);
         end
         pc(32'h0000031A);
         for (m = 0; m < 8; m = m + 1)
         begin
            send(16'h0040, m[2:0], 1'h1, 1'h0, 6'h0, 2'h0, 1'h0, 3'h0);
            chk("queue", res_queue, m / 2);
         end
         pc(32'h00004352);
         send(16'h0040, 3'h6, 1'h1, 1'h0, 6'h0, 2'h0, 1'h0, 3'h0);
         chk("pcp", res_pcp, 3'h2);
         chk("queue", res_queue, 2'h1);
         wr(9'h114, 32'h00000003);
         rdc(9'h114, 32'h00000003);
         pc(32'h00000332);
         send(16'h0040, 3'h0, 1'h1, 1'h1, 6'h05, 2'h0, 1'h0, 3'h0);
         chk("queue", res_queue, 2'h3);
         pc(32'h00000331);
         send(16'h0040, 3'h0, 1'h1, 1'h1, 6'h05, 2'h0, 1'h0, 3'h0);
         chk("queue", res_queue, 2'h1);
      end
   endtask
   task t_meter;
      begin
         pc(32'h00000300);
         wr(9'h008, 32'h00640064);
         wr(9'h00C, 32'h00C800C8);
         sd(16'h0032, 2'h2, 1'h0, 3'h0);
         chk("colour", res_color, `SQS_COL_GREEN);
         sd(16'h0096, 2'h0, 1'h0, 3'h0);
         chk("colour", res_color, `SQS_COL_YELLOW);
         sd(16'h00FA, 2'h0, 1'h0, 3'h0);
         chk("colour", res_color, `SQS_COL_RED);
         pc(32'h00000B00);
         sd(16'h0032, 2'h2, 1'h0, 3'h0);
         chk("colour", res_color, `SQS_COL_RED);
         sd(16'h0032, 2'h1, 1'h0, 3'h0);
         chk("colour", res_color, `SQS_COL_YELLOW);
      end
   endtask
   task dep(input [11:0] t, input [11:0] o, input s, input e);
      begin
         @(posedge core_clk);
         tc_depth <= t;
         mem_occupancy <= o;
         repeat (200) @(posedge core_clk);
         sd(16'h0040, 2'h0, s, 3'h0);
         chk("drop", res_drop, e);
      end
   endtask
   task t_wred;
      begin
         pc(32'h00001300);
         dep(12'h800, 12'h000, 1'h0, 1'h0);
         dep(12'hC01, 12'h000, 1'h0, 1'h1);
         dep(12'hC01, 12'h000, 1'h1, 1'h0);
         dep(12'h000, 12'hFFF, 1'h0, 1'h1);
         dep(12'h000, 12'h000, 1'h0, 1'h0);
         rdc(`SQS_OFS_STATUS, 32'h00020000);
      end
   endtask
   task stp(input [31:0] c, input [2:0] h, input [2:0] st, input f,
            input [1:0] l);
      begin
         pc(c);
         sd(16'h0040, 2'h0, 1'h0, h);
         chk("stp_state", stp_state, st);
         chk("forward", res_forward, f);
         if (l != 2'h2)
            chk("learn", res_learn, l);
      end
   endtask
   task t_stp;
      begin
         stp(32'h00000300, 3'h0, `SQS_STP_FORWARD, 1'h1, 2'h1);
         stp(32'h00000000, 3'h0, `SQS_STP_LEARNING, 1'h0, 2'h1);
         stp(32'h00000000, 3'h4, `SQS_STP_LEARNING, 1'h1, 2'h1);
         stp(32'h00020400, 3'h2, `SQS_STP_LISTENING, 1'h1, 2'h0);
         stp(32'h00020400, 3'h0, `SQS_STP_LISTENING, 1'h0, 2'h0);
         stp(32'h00010400, 3'h4, `SQS_STP_BLOCKING, 1'h0, 2'h0);
         stp(32'h00010400, 3'h5, `SQS_STP_BLOCKING, 1'h1, 2'h0);
         stp(32'h00000400, 3'h5, `SQS_STP_DISABLE, 1'h1, 2'h0);
         stp(32'h00000400, 3'h0, `SQS_STP_DISABLE, 1'h0, 2'h0);
         stp(32'h00000480, 3'h0, `SQS_STP_HOST, 1'h1, 2'h2);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial
   begin
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      srst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, rq} = '0;
      {frm_len, frm_pcp, frm_tagged, frm_is_ip, frm_dscp, frm_color,
       frm_sr, frm_to_host, frm_from_host, frm_ovr_hit} = '0;
      {mem_occupancy, tc_depth} = '0;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      t_regs;
      t_queue;
      t_meter;
      t_wred;
      t_stp;
      final_report;
   end
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
endmodule

// ===== hw/sqs_dscp_mem.v
`timescale 1ns/100ps
module sqs_dscp_mem
(
   input  wire       core_clk,
   input  wire       srst,
   input  wire       wr_en,
   input  wire [5:0] wr_idx,
   input  wire [1:0] wr_data,
   input  wire [5:0] bus_idx,
   output reg  [1:0] bus_data,
   input  wire [5:0] lkp_idx,
   output reg  [1:0] lkp_data
);

   wire [127:0] table_flat;

   // ----------------------------------------------------------------
   // One 2-bit queue selector per DSCP code point
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 64; g = g + 1)
      begin : ent
         reg [1:0] sel_r;
         always @(posedge core_clk)
         begin
            if (srst)
               sel_r <= 2'h0;
            else if (wr_en && (wr_idx == g))
               sel_r <= wr_data;
         end
         assign table_flat[2*g+1:2*g] = sel_r;
      end
   endgenerate

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         bus_data <= 2'h0;
         lkp_data <= 2'h0;
      end
      else
      begin
         bus_data <= table_flat[{bus_idx, 1'b0} +: 2];
         lkp_data <= table_flat[{lkp_idx, 1'b0} +: 2];
      end
   end

endmodule

// ===== hw/sqs_policy.v
`timescale 1ns/100ps
`include "sqs_policy_regs.vh"
module sqs_policy
(
   input  wire        core_clk,
   input  wire        srst,
   input  wire [8:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output wire [31:0] reg_rdata,
   input  wire        frm_valid,
   input  wire [15:0] frm_len,
   input  wire        frm_tagged,
   input  wire [2:0]  frm_pcp,
   input  wire        frm_is_ip,
   input  wire [5:0]  frm_dscp,
   input  wire [1:0]  frm_color,
   input  wire        frm_sr,
   input  wire        frm_to_host,
   input  wire        frm_from_host,
   input  wire        frm_ovr_hit,
   input  wire [11:0] mem_occupancy,
   input  wire [11:0] tc_depth,
   output reg         res_valid,
   output reg  [1:0]  res_queue,
   output reg  [2:0]  res_pcp,
   output reg  [1:0]  res_color,
   output reg         res_drop,
   output reg         res_forward,
   output reg         res_learn,
   output wire [1:0]  cfg_queue_mode,
   output wire        cfg_wrr,
   output reg  [2:0]  stp_state,
   output wire        host_port
);

   reg  [31:0] port_ctrl_r;
   reg  [15:0] pcp_map_r;
   reg  [31:0] cir_r;
   reg  [31:0] pir_r;
   reg  [31:0] wred_r;
   reg  [15:0] drop_cnt_r;
   reg  [1:0]  last_color_r;
   reg  [31:0] rd_data_r;
   reg         rd_dscp_r;
   reg         s1_valid_r;
   reg  [15:0] s1_len_r;
   reg         s1_tagged_r;
   reg  [2:0]  s1_pcp_r;
   reg         s1_is_ip_r;
   reg  [1:0]  s1_color_r;
   reg         s1_sr_r;
   reg         s1_to_host_r;
   reg         s1_from_host_r;
   reg         s1_ovr_r;
   reg  [15:0] tc_r;
   reg  [15:0] tp_r;
   reg  [15:0] tc_nxt;
   reg  [15:0] tp_nxt;
   reg  [1:0]  color_nxt;
   reg  [1:0]  class_nxt;
   reg  [1:0]  queue_nxt;
   reg         permit_nxt;
   reg         learn_nxt;
   reg  [2:0]  stp_nxt;
   reg  [31:0] rd_mux;
   wire [2:0]  def_prio;
   wire [2:0]  pcp_eff;
   wire [1:0]  pcp_class;
   wire [1:0]  dscp_class;
   wire [1:0]  dscp_bus;
   wire        dscp_wr;
   wire        dscp_acc;
   wire        wred_drop;
   wire [11:0] avg_depth;
   wire [16:0] tc_sum;
   wire [16:0] tp_sum;
   wire [15:0] tc_fill;
   wire [15:0] tp_fill;
   wire        aware;

   // ----------------------------------------------------------------
   // Register write port
   // ----------------------------------------------------------------
   assign dscp_acc = (reg_addr[8] == `SQS_DSCP_REGION)
                   & (reg_addr[1:0] == 2'h0);
   assign dscp_wr  = reg_wr & dscp_acc;

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         port_ctrl_r <= `SQS_RST_PORT_CTRL;
         pcp_map_r   <= `SQS_RST_PCP_MAP;
         cir_r       <= `SQS_RST_RATE;
         pir_r       <= `SQS_RST_RATE;
         wred_r      <= `SQS_RST_WRED;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `SQS_OFS_PORT_CTRL : port_ctrl_r <= {14'h0000, reg_wdata[17:0]};
            `SQS_OFS_PCP_MAP   : pcp_map_r   <= reg_wdata[15:0];
            `SQS_OFS_CIR       : cir_r       <= reg_wdata;
            `SQS_OFS_PIR       : pir_r       <= reg_wdata;
            `SQS_OFS_WRED      : wred_r      <= reg_wdata;
            default            : ;
         endcase
      end
   end

   assign cfg_queue_mode = port_ctrl_r[`SQS_QMODE_LSB +: 2];
   assign cfg_wrr        = port_ctrl_r[`SQS_WRR_BIT];
   assign host_port      = port_ctrl_r[`SQS_TAIL_TAG_BIT];
   assign def_prio       = port_ctrl_r[`SQS_DEF_PRIO_LSB +: 3];
   assign aware          = port_ctrl_r[`SQS_AWARE_BIT];

   // ----------------------------------------------------------------
   // Register read port, data in the cycle after the strobe
   // ----------------------------------------------------------------
   always @*
   begin
      rd_mux = 32'h00000000;
      case (reg_addr)
         `SQS_OFS_PORT_CTRL : rd_mux = port_ctrl_r;
         `SQS_OFS_PCP_MAP   : rd_mux = {16'h0000, pcp_map_r};
         `SQS_OFS_CIR       : rd_mux = cir_r;
         `SQS_OFS_PIR       : rd_mux = pir_r;
         `SQS_OFS_WRED      : rd_mux = wred_r;
         `SQS_OFS_STATUS    : rd_mux = {drop_cnt_r, 2'h0, last_color_r,
                                        avg_depth};
         default            : rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_data_r <= 32'h00000000;
         rd_dscp_r <= 1'b0;
      end
      else
      begin
         rd_data_r <= reg_rd ? rd_mux : 32'h00000000;
         rd_dscp_r <= reg_rd & dscp_acc;
      end
   end

   assign reg_rdata = rd_dscp_r ? {30'h00000000, dscp_bus} : rd_data_r;

   // ----------------------------------------------------------------
   // DSCP table, looked up by frm_dscp as the frame enters stage one
   // ----------------------------------------------------------------
   sqs_dscp_mem u_dscp
   (
      .core_clk (core_clk),
      .srst     (srst),
      .wr_en    (dscp_wr),
      .wr_idx   (reg_addr[7:2]),
      .wr_data  (reg_wdata[1:0]),
      .bus_idx  (reg_addr[7:2]),
      .bus_data (dscp_bus),
      .lkp_idx  (frm_dscp),
      .lkp_data (dscp_class)
   );

   // ----------------------------------------------------------------
   // Stage one: hold frame descriptor
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         s1_valid_r     <= 1'b0;
         s1_len_r       <= 16'h0000;
         s1_tagged_r    <= 1'b0;
         s1_pcp_r       <= 3'h0;
         s1_is_ip_r     <= 1'b0;
         s1_color_r     <= 2'h0;
         s1_sr_r        <= 1'b0;
         s1_to_host_r   <= 1'b0;
         s1_from_host_r <= 1'b0;
         s1_ovr_r       <= 1'b0;
      end
      else
      begin
         s1_valid_r     <= frm_valid;
         s1_len_r       <= frm_len;
         s1_tagged_r    <= frm_tagged;
         s1_pcp_r       <= frm_pcp;
         s1_is_ip_r     <= frm_is_ip;
         s1_color_r     <= frm_color;
         s1_sr_r        <= frm_sr;
         s1_to_host_r   <= frm_to_host;
         s1_from_host_r <= frm_from_host;
         s1_ovr_r       <= frm_ovr_hit;
      end
   end

   // ----------------------------------------------------------------
   // Priority classification
   // ----------------------------------------------------------------
   assign pcp_eff = (port_ctrl_r[`SQS_CEIL_EN_BIT] && (s1_pcp_r > def_prio))
                  ? def_prio : s1_pcp_r;
   assign pcp_class = pcp_map_r[{pcp_eff, 1'b0} +: 2];

   always @*
   begin
      if (port_ctrl_r[`SQS_DSCP_EN_BIT] && s1_is_ip_r)
         class_nxt = dscp_class;
      else if (port_ctrl_r[`SQS_PCP_EN_BIT] && s1_tagged_r)
         class_nxt = pcp_class;
      else
         class_nxt = port_ctrl_r[`SQS_PORT_HI_BIT] ? 2'h3 : 2'h0;
      case (cfg_queue_mode)
         `SQS_QMODE_4Q : queue_nxt = class_nxt;
         `SQS_QMODE_2Q : queue_nxt = {1'b0, class_nxt[1]};
         default       : queue_nxt = 2'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // Two-rate three-colour meter
   // ----------------------------------------------------------------
   assign tc_sum  = {1'b0, tc_r} + {1'b0, cir_r[15:0]};
   assign tp_sum  = {1'b0, tp_r} + {1'b0, pir_r[15:0]};
   assign tc_fill = (tc_sum > {1'b0, cir_r[31:16]}) ? cir_r[31:16]
                  : tc_sum[15:0];
   assign tp_fill = (tp_sum > {1'b0, pir_r[31:16]}) ? pir_r[31:16]
                  : tp_sum[15:0];

   always @*
   begin
      tc_nxt    = tc_fill;
      tp_nxt    = tp_fill;
      color_nxt = `SQS_COL_GREEN;
      if (s1_valid_r)
      begin
         if ((aware && (s1_color_r == `SQS_COL_RED))
             || (tp_r < s1_len_r))
            color_nxt = `SQS_COL_RED;
         else if ((aware && (s1_color_r == `SQS_COL_YELLOW))
                  || (tc_r < s1_len_r))
         begin
            color_nxt = `SQS_COL_YELLOW;
            tp_nxt    = (tp_fill > s1_len_r) ? (tp_fill - s1_len_r)
                      : 16'h0000;
         end
         else
         begin
            color_nxt = `SQS_COL_GREEN;
            tp_nxt    = (tp_fill > s1_len_r) ? (tp_fill - s1_len_r)
                      : 16'h0000;
            tc_nxt    = (tc_fill > s1_len_r) ? (tc_fill - s1_len_r)
                      : 16'h0000;
         end
      end
   end

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         tc_r <= 16'h0000;
         tp_r <= 16'h0000;
      end
      else
      begin
         tc_r <= tc_nxt;
         tp_r <= tp_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Weighted random early drop
   // ----------------------------------------------------------------
   sqs_wred u_wred
   (
      .core_clk      (core_clk),
      .srst          (srst),
      .mem_occupancy (mem_occupancy),
      .tc_depth      (tc_depth),
      .min_th        (wred_r[11:0]),
      .max_th        (wred_r[23:12]),
      .mult          (wred_r[31:24]),
      .exempt        (port_ctrl_r[`SQS_SR_EXEMPT_BIT] & s1_sr_r),
      .drop          (wred_drop),
      .avg_depth     (avg_depth)
   );

   // ----------------------------------------------------------------
   // Spanning tree state and frame gating
   // ----------------------------------------------------------------
   always @*
   begin
      if (host_port)
         stp_nxt = `SQS_STP_HOST;
      else
         case ({port_ctrl_r[`SQS_TX_EN_BIT], port_ctrl_r[`SQS_RX_EN_BIT],
                port_ctrl_r[`SQS_LRN_DIS_BIT]})
            3'h6    : stp_nxt = `SQS_STP_FORWARD;
            3'h0    : stp_nxt = `SQS_STP_LEARNING;
            3'h1    :
               case (port_ctrl_r[`SQS_DISC_SUB_LSB +: 2])
                  `SQS_SUB_BLOCKING  : stp_nxt = `SQS_STP_BLOCKING;
                  `SQS_SUB_LISTENING : stp_nxt = `SQS_STP_LISTENING;
                  default            : stp_nxt = `SQS_STP_DISABLE;
               endcase
            default : stp_nxt = `SQS_STP_DISABLE;
         endcase
   end

   always @*
   begin
      permit_nxt = 1'b0;
      learn_nxt  = 1'b0;
      case (stp_nxt)
         `SQS_STP_HOST, `SQS_STP_FORWARD :
         begin
            permit_nxt = 1'b1;
            learn_nxt  = ~s1_from_host_r;
         end
         `SQS_STP_LEARNING :
         begin
            permit_nxt = s1_to_host_r | s1_from_host_r;
            learn_nxt  = ~s1_from_host_r;
         end
         `SQS_STP_LISTENING :
            permit_nxt = s1_to_host_r | s1_from_host_r;
         default :
            permit_nxt = s1_to_host_r & s1_ovr_r;
      endcase
   end

   // ----------------------------------------------------------------
   // Stage two: result and status
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         res_valid    <= 1'b0;
         res_queue    <= 2'h0;
         res_pcp      <= 3'h0;
         res_color    <= `SQS_COL_GREEN;
         res_drop     <= 1'b0;
         res_forward  <= 1'b0;
         res_learn    <= 1'b0;
         stp_state    <= `SQS_STP_FORWARD;
         drop_cnt_r   <= 16'h0000;
         last_color_r <= `SQS_COL_GREEN;
      end
      else
      begin
         res_valid <= s1_valid_r;
         stp_state <= stp_nxt;
         if (s1_valid_r)
         begin
            res_queue    <= queue_nxt;
            res_pcp      <= pcp_eff;
            res_color    <= color_nxt;
            res_drop     <= wred_drop;
            res_forward  <= permit_nxt;
            res_learn    <= learn_nxt;
            last_color_r <= color_nxt;
            if (wred_drop && (drop_cnt_r != 16'hFFFF))
               drop_cnt_r <= drop_cnt_r + 16'h0001;
         end
      end
   end

endmodule

// ===== hw/sqs_policy_regs.vh
// Summary of operation
// - Each port runs one, two or four egress queues; one queue after reset.
// - Queue 3 is highest of four, queue 0 lowest; queue 1 highest of two.
// - A single-queue port sends high and low priority frames alike.
// - Per-port choice between strict priority and weighted round robin.
// - A high-priority port marks high, using the high queue, every frame that DSCP or 802.1p mode does not classify.
// - Tagged frames in 802.1p mode index a programmable map by PCP.
// - With the ceiling on, a PCP above the default tag becomes that tag.
// - DSCP mode indexes a programmable table by DSCP giving a 2-bit queue.
// - Red above peak rate, else yellow above committed rate, else green.
// - Colour-blind ignores incoming colour; colour-aware honours it.
// - Early drop watches average memory occupancy and class queue depth.
// - At or below the minimum threshold every frame is accepted.
// - Drop chance grows linearly to the multiplier at the maximum.
// - Above the maximum threshold every frame is discarded.
// - Stream-reservation classes may be exempted from early drop.
// - The tail-tagged port is the host port; others follow three bits.
// - Disable state neither forwards nor receives nor learns.
// - Disable and blocking still send override-matched frames to host.
// - Listening passes only host traffic without learning.
// - Learning state passes only host traffic but learns addresses.
// - Forwarding state passes all frames and learns addresses.
`ifndef SQS_POLICY_REGS_VH
`define SQS_POLICY_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SQS_ADDR_W        9
`define SQS_OFS_PORT_CTRL 9'h000
`define SQS_OFS_PCP_MAP   9'h004
`define SQS_OFS_CIR       9'h008
`define SQS_OFS_PIR       9'h00C
`define SQS_OFS_WRED      9'h010
`define SQS_OFS_STATUS    9'h014
`define SQS_DSCP_REGION   1'h1

// ----------------------------------------------------------------
// Port control fields
// ----------------------------------------------------------------
`define SQS_QMODE_LSB     0
`define SQS_WRR_BIT       2
`define SQS_PORT_HI_BIT   3
`define SQS_PCP_EN_BIT    4
`define SQS_DSCP_EN_BIT   5
`define SQS_CEIL_EN_BIT   6
`define SQS_TAIL_TAG_BIT  7
`define SQS_TX_EN_BIT     8
`define SQS_RX_EN_BIT     9
`define SQS_LRN_DIS_BIT   10
`define SQS_AWARE_BIT     11
`define SQS_SR_EXEMPT_BIT 12
`define SQS_DEF_PRIO_LSB  13
`define SQS_DISC_SUB_LSB  16

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define SQS_QMODE_1Q      2'h0
`define SQS_QMODE_2Q      2'h1
`define SQS_QMODE_4Q      2'h2
`define SQS_SUB_DISABLE   2'h0
`define SQS_SUB_BLOCKING  2'h1
`define SQS_SUB_LISTENING 2'h2
`define SQS_COL_GREEN     2'h0
`define SQS_COL_YELLOW    2'h1
`define SQS_COL_RED       2'h2
`define SQS_STP_DISABLE   3'h0
`define SQS_STP_BLOCKING  3'h1
`define SQS_STP_LISTENING 3'h2
`define SQS_STP_LEARNING  3'h3
`define SQS_STP_FORWARD   3'h4
`define SQS_STP_HOST      3'h5
`define SQS_RST_PORT_CTRL 32'h00000300
`define SQS_RST_PCP_MAP   16'hFA50
`define SQS_RST_RATE      32'hFFFFFFFF
`define SQS_RST_WRED      32'h40C00800
`define SQS_EWMA_SHIFT    3
`define SQS_LFSR_SEED     16'hACE1

`endif

// ===== hw/sqs_wred.v
`timescale 1ns/100ps
`include "sqs_policy_regs.vh"
module sqs_wred
(
   input  wire        core_clk,
   input  wire        srst,
   input  wire [11:0] mem_occupancy,
   input  wire [11:0] tc_depth,
   input  wire [11:0] min_th,
   input  wire [11:0] max_th,
   input  wire [7:0]  mult,
   input  wire        exempt,
   output wire        drop,
   output wire [11:0] avg_depth
);

   reg  [14:0] acc_r;
   reg  [15:0] lfsr_r;
   wire [15:0] acc_sum;
   wire [11:0] depth;
   wire [11:0] span;
   wire [11:0] excess;
   wire [19:0] lhs;
   wire [19:0] rhs;

   // ----------------------------------------------------------------
   // Running average of packet memory occupancy
   // ----------------------------------------------------------------
   assign acc_sum   = {1'b0, acc_r} - {4'h0, acc_r[14:`SQS_EWMA_SHIFT]}
                    + {4'h0, mem_occupancy};
   assign avg_depth = acc_r[14:`SQS_EWMA_SHIFT];

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         acc_r  <= 15'h0000;
         lfsr_r <= `SQS_LFSR_SEED;
      end
      else
      begin
         acc_r  <= acc_sum[14:0];
         lfsr_r <= {lfsr_r[14:0],
                    lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end

   // ----------------------------------------------------------------
   // Drop decision on the worse of memory average and class depth
   // ----------------------------------------------------------------
   assign depth  = (avg_depth > tc_depth) ? avg_depth : tc_depth;
   assign span   = (max_th > min_th) ? (max_th - min_th) : 12'h000;
   assign excess = (depth > min_th) ? (depth - min_th) : 12'h000;
   // Chance = mult/256 * excess/span, compared without a divider
   assign lhs    = lfsr_r[7:0] * span;
   assign rhs    = mult * excess;
   assign drop   = ~exempt & ((depth > max_th) |
                   ((depth > min_th) & (lhs < rhs)));

endmodule
